/* File: pkg/lpd_map.svh */
// Register indices, field values and timing figures of the panel drive block.
// Assumes inclusion by bare name wherever the block or its bench needs a figure.
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH
// Address map: bytes below the register page are the embedded memory.
`define LPD_MEM_BYTES 32768
`define LPD_REG_PAGE 8'h80
`define LPD_IDX_MEMCFG 8'h00
`define LPD_IDX_PWRSAVE 8'h08
`define LPD_IDX_DISPEN 8'h09
`define LPD_IDX_STATUS 8'h21
`define LPD_MEMCFG_RST 8'h10
`define LPD_CMD_DISP_OFF 8'h58
// Divider select codes and the matching last count of the divider.
`define LPD_SEL_DIV4 2'h0
`define LPD_SEL_DIV8 2'h1
`define LPD_SEL_DIV16 2'h2
`define LPD_LAST_DIV4 4'h3
`define LPD_LAST_DIV8 4'h7
`define LPD_LAST_DIV16 4'hf
// Positions in shift periods inside a line.
`define LPD_CNT_W 10
`define LPD_POS_COLEN 10'h000
`define LPD_POS_FR_RISE 10'h000
`define LPD_POS_LINE 10'h002
`define LPD_POS_FR_FALL 10'h006
// Timing figures.
`define LPD_TS_NS 100
`define LPD_T1B_EXTRA_NS 10
`define LPD_T1C_EXTRA_NS 10
`define LPD_CLK_HZ 10000000
`define LPD_PSC_MAX_HZ 15000000
`endif

/* File: pkg/lpd_pkg.sv */
// Types shared by the panel drive block and its bench.
// Assumes the map header is compiled alongside for the figures.
package lpd_pkg;
    // Power save sequencing: a request waits for a frame boundary.
    typedef enum logic [1:0] {
        LPD_PS_RUN = 2'b00,
        LPD_PS_PEND = 2'b01,
        LPD_PS_SAVE = 2'b10
    } lpd_ps_t;
    // Everything that leaves the block towards the panel.
    typedef struct packed {
        logic pixel_shift_clock;
        logic line_pulse;
        logic frame_pulse;
        logic row_scan_clock;
        logic column_enable_clock;
        logic ac_drive_toggle;
        logic panel_blank_out;
        logic [3:0] panel_pixel_bits;
    } lpd_panel_t;
endpackage

/* File: hdl/lpd_top.sv */
// Panel drive and blanking control for a 4-bit monochrome panel.
// Assumes a single 10 MHz clock, synchronous inputs and a one-cycle register port.
`timescale 1ns/1ns
`include "lpd_map.svh"

module lpd_top #(
    parameter int PIX_PER_LINE = 80,
    parameter int LINES_PER_FRAME = 240
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [1:0] shift_divider_select,
    input wire logic indirect_mode,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    output lpd_pkg::lpd_panel_t panel
);

    localparam logic [`LPD_CNT_W-1:0] LAST_PIX = `LPD_CNT_W'(PIX_PER_LINE - 1);
    localparam logic [`LPD_CNT_W-1:0] LAST_LINE = `LPD_CNT_W'(LINES_PER_FRAME - 1);
    localparam int OFF_CMD_CYC = (1 * `LPD_TS_NS + `LPD_T1B_EXTRA_NS) / `LPD_TS_NS;
    localparam int DIR_CYC = (2 * `LPD_TS_NS + `LPD_T1C_EXTRA_NS) / `LPD_TS_NS;

    logic [7:0] mem [0:`LPD_MEM_BYTES-1];
    logic [7:0] memcfg_ff, nxt_memcfg;
    logic disp_ff, nxt_disp;
    lpd_pkg::lpd_ps_t ps_ff, nxt_ps;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [3:0] div_ff, nxt_div;
    logic [`LPD_CNT_W-1:0] pix_ff, nxt_pix, line_ff, nxt_line;
    logic [15:0] nib_ff, nxt_nib;
    lpd_pkg::lpd_panel_t panel_ff, nxt_panel;
    logic reg_page, wr_reg, rd_reg, tg_rst, cmd_off, tick, frame_end;
    logic [3:0] div_last;
    logic [7:0] idx, scan_byte;

    assign reg_page = (bus_addr[15:8] == `LPD_REG_PAGE);
    assign idx = bus_addr[7:0];
    assign wr_reg = bus_wr && reg_page;
    assign rd_reg = bus_rd && reg_page;
    assign cmd_off = cmd_valid && indirect_mode && (cmd_code == `LPD_CMD_DISP_OFF);
    assign tg_rst = wr_reg && (idx == `LPD_IDX_MEMCFG);
    assign bus_rdata = rdata_ff;
    assign panel = panel_ff;

    // Single memory for display data; the host writes the low half of the map.
    always_ff @(posedge clk)
    begin
        if (ce && bus_wr && !bus_addr[15])
        begin
            mem[bus_addr[14:0]] <= bus_wdata;
        end
    end

    // Control state: display enable clears are applied first so a same-cycle set wins; power save clears win over frame entry.
    always_comb
    begin
        nxt_memcfg = memcfg_ff;
        nxt_disp = disp_ff;
        nxt_ps = ps_ff;
        if (tg_rst)
        begin
            nxt_memcfg = bus_wdata;
            nxt_disp = 1'b0;
        end
        if (cmd_off)
        begin
            nxt_disp = 1'b0;
        end
        if (wr_reg && idx == `LPD_IDX_DISPEN)
        begin
            nxt_disp = bus_wdata[0];
        end
        unique case (ps_ff)
            lpd_pkg::LPD_PS_RUN:
            begin
                if (wr_reg && idx == `LPD_IDX_PWRSAVE && bus_wdata[0])
                begin
                    nxt_ps = lpd_pkg::LPD_PS_PEND;
                end
            end
            lpd_pkg::LPD_PS_PEND:
            begin
                if (wr_reg && idx == `LPD_IDX_PWRSAVE && !bus_wdata[0])
                begin
                    nxt_ps = lpd_pkg::LPD_PS_RUN;
                end
                else if (frame_end)
                begin
                    nxt_ps = lpd_pkg::LPD_PS_SAVE;
                end
            end
            lpd_pkg::LPD_PS_SAVE:
            begin
                if (wr_reg && idx == `LPD_IDX_PWRSAVE && !bus_wdata[0])
                begin
                    nxt_ps = lpd_pkg::LPD_PS_RUN;
                end
            end
            default:
            begin
                nxt_ps = lpd_pkg::LPD_PS_RUN;
            end
        endcase
        if (tg_rst && indirect_mode)
        begin
            nxt_ps = lpd_pkg::LPD_PS_RUN;
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (bus_rd && !bus_addr[15])
        begin
            nxt_rdata = mem[bus_addr[14:0]];
        end
        else if (rd_reg)
        begin
            case (idx)
                `LPD_IDX_MEMCFG: nxt_rdata = memcfg_ff;
                `LPD_IDX_PWRSAVE: nxt_rdata = {7'h00, ps_ff != lpd_pkg::LPD_PS_RUN};
                `LPD_IDX_DISPEN: nxt_rdata = {7'h00, disp_ff};
                `LPD_IDX_STATUS: nxt_rdata = {5'h00, panel_ff.frame_pulse,
                    panel_ff.panel_blank_out, ps_ff == lpd_pkg::LPD_PS_SAVE};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            memcfg_ff <= `LPD_MEMCFG_RST;
            disp_ff <= 1'b0;
            ps_ff <= lpd_pkg::LPD_PS_RUN;
            rdata_ff <= 8'h00;
        end
        else if (ce)
        begin
            memcfg_ff <= nxt_memcfg;
            disp_ff <= nxt_disp;
            ps_ff <= nxt_ps;
            rdata_ff <= nxt_rdata;
        end
    end

    // Divider ratio; the unsupported code takes the slowest ratio.
    always_comb
    begin
        case (shift_divider_select)
            `LPD_SEL_DIV4: div_last = `LPD_LAST_DIV4;
            `LPD_SEL_DIV8: div_last = `LPD_LAST_DIV8;
            `LPD_SEL_DIV16: div_last = `LPD_LAST_DIV16;
            default: div_last = `LPD_LAST_DIV16;
        endcase
    end

    // A ratio cut mid-period to a last count at or below the current count ends the period at once rather than wrapping.
    assign tick = (div_ff >= div_last);
    assign frame_end = tick && (pix_ff == LAST_PIX) && (line_ff == LAST_LINE);
    assign scan_byte = mem[nib_ff[15:1]];

    // Timing generator: counters, then panel signals from the next counts.
    always_comb
    begin
        nxt_div = tick ? 4'h0 : div_ff + 4'h1;
        nxt_pix = pix_ff;
        nxt_line = line_ff;
        nxt_nib = nib_ff;
        nxt_panel = panel_ff;
        if (tick)
        begin
            nxt_pix = (pix_ff == LAST_PIX) ? '0 : pix_ff + 1'b1;
            nxt_nib = frame_end ? 16'h0000 : nib_ff + 16'h0001;
            nxt_panel.panel_pixel_bits = nib_ff[0] ? scan_byte[3:0] : scan_byte[7:4];
            if (pix_ff == LAST_PIX)
            begin
                nxt_line = (line_ff == LAST_LINE) ? '0 : line_ff + 1'b1;
            end
        end
        if (frame_end)
        begin
            nxt_panel.ac_drive_toggle = !panel_ff.ac_drive_toggle;
        end
        if (tg_rst)
        begin
            nxt_div = 4'h0;
            nxt_pix = '0;
            nxt_line = '0;
            nxt_nib = 16'h0000;
        end
        nxt_panel.pixel_shift_clock = (nxt_div <= (div_last >> 1));
        nxt_panel.line_pulse = (nxt_pix == `LPD_POS_LINE);
        nxt_panel.row_scan_clock = (nxt_pix == `LPD_POS_LINE);
        nxt_panel.column_enable_clock = (nxt_pix == `LPD_POS_COLEN);
        // A restart holds the frame pulse one cycle, so a cut line pulse never ends on its edge.
        nxt_panel.frame_pulse = tg_rst ? panel_ff.frame_pulse
            : (nxt_line == '0) && (nxt_pix >= `LPD_POS_FR_RISE)
            && (nxt_pix < `LPD_POS_FR_FALL);
        nxt_panel.panel_blank_out = nxt_disp && (nxt_ps != lpd_pkg::LPD_PS_SAVE);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_ff <= 4'h0;
            pix_ff <= '0;
            line_ff <= '0;
            nib_ff <= 16'h0000;
            panel_ff <= '0;
        end
        else if (ce)
        begin
            div_ff <= nxt_div;
            pix_ff <= nxt_pix;
            line_ff <= nxt_line;
            nib_ff <= nxt_nib;
            panel_ff <= nxt_panel;
        end
    end

    // Helper counts for the checks: clocks per period and shift periods between edges.
    logic [4:0] gap_ff;
    logic gap_ok_ff;
    logic [1:0] sel_prev_ff;
    logic [3:0] fr_ticks_ff, ln_ticks_ff;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gap_ff <= 5'h00;
            gap_ok_ff <= 1'b0;
            sel_prev_ff <= 2'h0;
            fr_ticks_ff <= 4'h0;
            ln_ticks_ff <= 4'h0;
        end
        else if (ce)
        begin
            sel_prev_ff <= shift_divider_select;
            gap_ff <= (tick || tg_rst) ? 5'h00 : gap_ff + 5'h01;
            gap_ok_ff <= (tick && !tg_rst && shift_divider_select == sel_prev_ff)
                || (gap_ok_ff && !tick && !tg_rst && shift_divider_select == sel_prev_ff);
            if (tick && panel_ff.frame_pulse && fr_ticks_ff != 4'hf)
            begin
                fr_ticks_ff <= fr_ticks_ff + 4'h1;
            end
            else if (!panel_ff.frame_pulse)
            begin
                fr_ticks_ff <= 4'h0;
            end
            if (panel_ff.line_pulse || panel_ff.row_scan_clock)
            begin
                ln_ticks_ff <= 4'h0;
            end
            else if (tick && ln_ticks_ff != 4'hf)
            begin
                ln_ticks_ff <= ln_ticks_ff + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    div_period_a: assert property (ce && tick && gap_ok_ff
        && shift_divider_select == sel_prev_ff |-> gap_ff == {1'b0, div_last})
        else $error("shift period does not match divider select");
    div_fallback_a: assert property (shift_divider_select == 2'h3 |-> div_last == `LPD_LAST_DIV16)
        else $error("unsupported select did not fall back to divide by sixteen");
    shift_rate_a: assert property (`LPD_CLK_HZ / (int'(div_last) + 1)
        <= `LPD_PSC_MAX_HZ) else $error("shift clock faster than its ceiling");
    cmd_off_a: assert property (ce && cmd_off && !(wr_reg && idx == `LPD_IDX_DISPEN)
        |-> ##[1:OFF_CMD_CYC] !panel.panel_blank_out)
        else $error("display off command did not blank the panel");
    dir_off_a: assert property (ce && wr_reg && idx == `LPD_IDX_DISPEN && !bus_wdata[0]
        |-> ##[1:DIR_CYC] !panel.panel_blank_out)
        else $error("clearing display enable did not blank the panel");
    disp_on_a: assert property (ce && wr_reg && idx == `LPD_IDX_DISPEN && bus_wdata[0]
        && ps_ff == lpd_pkg::LPD_PS_RUN |=> panel.panel_blank_out)
        else $error("display on did not raise the blanking output");
    ps_boundary_a: assert property (ce && ps_ff == lpd_pkg::LPD_PS_PEND && !frame_end
        |=> ps_ff != lpd_pkg::LPD_PS_SAVE)
        else $error("power save entered away from a frame boundary");
    ps_blank_a: assert property (ps_ff == lpd_pkg::LPD_PS_SAVE |-> !panel.panel_blank_out)
        else $error("panel not blanked in power save");
    ps_readback_a: assert property (ce && wr_reg && idx == `LPD_IDX_PWRSAVE && bus_wdata[0]
        && ps_ff == lpd_pkg::LPD_PS_RUN |=> ps_ff == lpd_pkg::LPD_PS_PEND)
        else $error("power save request bit not taken");
    frame_line_a: assert property ($fell(panel.line_pulse) && panel.frame_pulse
        |-> fr_ticks_ff >= 4'h2)
        else $error("line pulse fell too soon after frame pulse rose");
    line_frame_a: assert property ($fell(panel.frame_pulse) |-> ln_ticks_ff >= 4'h2)
        else $error("frame pulse fell too soon after line pulse fell");
    scan_frame_a: assert property ($fell(panel.frame_pulse) |-> ln_ticks_ff >= 4'h3)
        else $error("frame pulse fell too soon after row scan clock fell");
    memcfg_reset_a: assert property (ce && tg_rst |=> !panel.panel_blank_out && pix_ff == '0
        && line_ff == '0 && memcfg_ff == $past(bus_wdata))
        else $error("memory configuration write did not reset timing and blank");

    ps_enter_c: cover property (ps_ff == lpd_pkg::LPD_PS_PEND ##1 ps_ff == lpd_pkg::LPD_PS_SAVE);
    cmd_off_c: cover property (cmd_off && panel.panel_blank_out);
    frame_c: cover property ($fell(panel.frame_pulse));

endmodule // lpd_top

/* File: tb/lpd_panel_model.sv */
// Panel stand-in that measures shift period and frame, line and row edge spacing.
// Assumes the panel outputs are sampled on the rising system clock edge.
`timescale 1ns/1ns

module lpd_panel_model (
    input wire logic clk,
    input wire lpd_pkg::lpd_panel_t panel,
    output logic [31:0] per_cyc,
    output logic [31:0] fr_line,
    output logic [31:0] line_fr,
    output logic [31:0] row_fr
);
    lpd_pkg::lpd_panel_t prev = '0;
    logic [31:0] n_sh = 0, n_fr = 0, n_ln = 0, n_row = 0;

    // A real panel only latches; counting clocks between edges exposes its margins.
    always @(posedge clk)
    begin
        prev <= panel;
        n_sh <= n_sh + 1;
        n_fr <= n_fr + 1;
        n_ln <= n_ln + 1;
        n_row <= n_row + 1;
        if (panel.pixel_shift_clock && !prev.pixel_shift_clock)
        begin
            per_cyc <= n_sh;
            n_sh <= 1;
        end
        if (panel.frame_pulse && !prev.frame_pulse)
            n_fr <= 1;
        if (!panel.line_pulse && prev.line_pulse)
        begin
            n_ln <= 1;
            if (panel.frame_pulse)
                fr_line <= n_fr;
        end
        if (!panel.row_scan_clock && prev.row_scan_clock)
            n_row <= 1;
        if (!panel.frame_pulse && prev.frame_pulse)
        begin
            line_fr <= n_ln;
            row_fr <= n_row;
        end
    end
endmodule // lpd_panel_model

/* File: tb/lpd_panel_drive_and_blanking_test.sv */
// Self-checking bench for the panel drive block with a measuring panel model.
// Assumes the map header and package are compiled first; frames are shortened.
`timescale 1ns/1ns
`include "lpd_map.svh"

module lpd_panel_drive_and_blanking_test;
    localparam int PIX = 8;
    localparam int LNS = 2;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [1:0] sel = 2'h0;
    logic ind = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] rdata;
    lpd_pkg::lpd_panel_t panel;
    logic [31:0] per_cyc, fr_line, line_fr, row_fr;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    lpd_top #(.PIX_PER_LINE(PIX), .LINES_PER_FRAME(LNS)) i_dut (
        .clk(clk), .resetn(resetn), .ce(ce), .shift_divider_select(sel),
        .indirect_mode(ind), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr),
        .bus_rd(rd), .bus_rdata(rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .panel(panel));

    lpd_panel_model i_panel (.clk(clk), .panel(panel), .per_cyc(per_cyc),
        .fr_line(fr_line), .line_fr(line_fr), .row_fr(row_fr));

    // 100 ns period for the 10 MHz system clock.
    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hang costs a mismatch; the whole run needs well under this many cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s seen %0h want %0h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample it there.
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic send_cmd(input logic [7:0] c);
        @(posedge clk);
        cmd_code <= c;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    // Gives the blanking output at most n clocks to reach the wanted level.
    task automatic blank_in(input logic lvl, input int n);
        for (int i = 0; i < n && panel.panel_blank_out !== lvl; i++)
            @(posedge clk) #1;
        check(panel.panel_blank_out, lvl, "blank level");
    endtask

    function automatic logic [31:0] exp_period(input logic [1:0] s);
        case (s)
            2'h0: return 32'h0000_0004;
            2'h1: return 32'h0000_0008;
            default: return 32'h0000_0010;
        endcase
    endfunction

    initial
    begin
        logic [7:0] v;
        logic [7:0] d;
        logic [15:0] a;
        lpd_pkg::lpd_panel_t p;
        void'($urandom(69816));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(16'h8000, v);
        check(v, `LPD_MEMCFG_RST, "memcfg reset");
        rd_reg(16'h8009, v);
        check(v, 8'h00, "enable reset");
        rd_reg(16'h8030, v);
        check(v, 8'h00, "unmapped read");
        check(panel.panel_blank_out, 1'b0, "blank after reset");
        $display("test reset done");
        // Direct mode switching on and off through the enable bit.
        wr_reg(16'h8009, 8'h01);
        blank_in(1'b1, 1);
        rd_reg(16'h8009, v);
        check(v, 8'h01, "enable readback");
        // The off command is refused outside indirect mode.
        send_cmd(`LPD_CMD_DISP_OFF);
        check(panel.panel_blank_out, 1'b1, "command in direct mode");
        wr_reg(16'h8009, 8'h00);
        blank_in(1'b0, 1);
        $display("test direct done");
        // Indirect mode: only the off command code may blank the panel.
        @(posedge clk) ind <= 1'b1;
        wr_reg(16'h8009, 8'h01);
        blank_in(1'b1, 1);
        repeat (4)
        begin
            d = 8'($urandom);
            if (d == `LPD_CMD_DISP_OFF)
                d = 8'h59;
            send_cmd(d);
            check(panel.panel_blank_out, 1'b1, "other command");
        end
        send_cmd(`LPD_CMD_DISP_OFF);
        blank_in(1'b0, 0);
        $display("test command done");
        // Every divider code, the unsupported one included, plus edge spacing.
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk) sel <= 2'(s);
            repeat (600) @(posedge clk);
            #1 check(per_cyc, exp_period(2'(s)), "shift period");
            check(`LPD_CLK_HZ / per_cyc <= `LPD_PSC_MAX_HZ, 1'b1, "shift rate");
            check(fr_line >= 2 * per_cyc, 1'b1, "frame to line");
            check(line_fr >= 2 * per_cyc, 1'b1, "line to frame");
            check(row_fr >= 3 * per_cyc, 1'b1, "row to frame");
        end
        @(posedge clk) sel <= 2'h0;
        $display("test divider done");
        // Power save, then a memcfg write that ends it in indirect mode.
        wr_reg(16'h8009, 8'h01);
        wr_reg(16'h8008, 8'h01);
        rd_reg(16'h8008, v);
        check(v, 8'h01, "save readback");
        blank_in(1'b0, 2 * PIX * LNS * 4);
        rd_reg(16'h8021, v);
        check(v & 8'h03, 8'h01, "save status");
        wr_reg(16'h8000, `LPD_MEMCFG_RST);
        rd_reg(16'h8008, v);
        check(v, 8'h00, "save ended");
        wr_reg(16'h8009, 8'h01);
        blank_in(1'b1, 1);
        wr_reg(16'h8000, `LPD_MEMCFG_RST);
        blank_in(1'b0, 1);
        $display("test power save done");
        // Random bytes across the memory, the top byte included.
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 16'h7fff : {1'b0, 15'($urandom)};
            d = 8'($urandom);
            wr_reg(a, d);
            rd_reg(a, v);
            check(v, d, "memory byte");
        end
        $display("test memory done");
        // Frame start: column enable in the first period, then byte 0 high nibble first.
        d = 8'($urandom);
        wr_reg(16'h0000, d);
        @(posedge panel.frame_pulse);
        #1 check(panel.column_enable_clock, 1'b1, "column enable at line start");
        repeat (5) @(posedge clk);
        #1 check(panel.panel_pixel_bits, d[7:4], "high nibble");
        check(panel.column_enable_clock, 1'b0, "column enable after start");
        repeat (4) @(posedge clk);
        #1 check(panel.panel_pixel_bits, d[3:0], "low nibble");
        // The drive toggle flips exactly once per frame of the shortened panel.
        v[0] = panel.ac_drive_toggle;
        repeat (PIX * LNS * exp_period(2'h0)) @(posedge clk);
        #1 check(panel.ac_drive_toggle, !v[0], "toggle per frame");
        $display("test panel done");
        // Clock enable low must freeze every panel output.
        @(posedge clk) ce <= 1'b0;
        @(posedge clk) #1 p = panel;
        repeat (20) @(posedge clk);
        #1 check(panel, p, "frozen with clock enable low");
        @(posedge clk) ce <= 1'b1;
        $display("test clock enable done");
        end_sim();
    end
endmodule // lpd_panel_drive_and_blanking_test
